// File: hdl/adcsq_map.vh
`ifndef ADCSQ_MAP_VH
`define ADCSQ_MAP_VH
`define ADCSQ_OFF_CTRL1   12'h000
`define ADCSQ_OFF_CTRL2   12'h004
`define ADCSQ_OFF_RESHI   12'h008
`define ADCSQ_OFF_RESLO   12'h00c
`define ADCSQ_OFF_IRQST   12'h010
`define ADCSQ_OFF_IRQMSK  12'h014
`define ADCSQ_C1_START    7
`define ADCSQ_C1_MODE_HI  6
`define ADCSQ_C1_MODE_LO  5
`define ADCSQ_C1_AINDIS   4
`define ADCSQ_C1_RESET    8'h0f
`define ADCSQ_C2_RESET    8'h10
`define ADCSQ_C2_WMASK    8'h3f
`define ADCSQ_LO_EOC      5
`define ADCSQ_LO_BUSY     4
`define ADCSQ_MODE_OFF    2'h0
`define ADCSQ_MODE_SINGLE 2'h1
`define ADCSQ_MODE_REPEAT 2'h3
`define ADCSQ_START_HOLD  3'h4
`define ADCSQ_FC_HZ       20000000
`define ADCSQ_CLK_HZ      20000000
`endif

// File: hdl/adcsq_result_mem.v
`timescale 1ns/10ps
`default_nettype none
module adcsq_result_mem #(
  parameter DEPTH = 4
) (
  input  wire       CLK_I,
  input  wire       RST_I,
  input  wire       wr_en_i,
  input  wire [1:0] wr_addr_i,
  input  wire [9:0] wr_data_i,
  input  wire [1:0] rd_addr_i,
  output reg  [9:0] rd_data_o
);
  reg [9:0] mem_reg [0:DEPTH-1];
  integer   i;
  // Last result per channel; read data registered
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (i = 0; i < DEPTH; i = i + 1)
        mem_reg[i] <= 10'h000;
      rd_data_o <= 10'h000;
    end else begin
      if (wr_en_i)
        mem_reg[wr_addr_i] <= wr_data_i;
      rd_data_o <= mem_reg[rd_addr_i];
    end
  end
endmodule // adcsq_result_mem
`default_nettype wire

// File: hdl/adcsq_top.v
// Function
// (R1) Codes 1..3 select channels; others none
// (R2) Change channel only while not busy
// (R3) Set input disable when no channel used
// (R4) Start bit clears itself once started
// (R5) No restart before end of conversion
// (R6) Reset loads reserved channel code
// (R7) Start ignored four cycles after zero write
// (R8) Control two bit0 zero, bit4 one
// (R9) Control two bits 7:6 read undefined
// (R10) Time codes pick 39..1248 clock periods
// (R11) Avoid inhibited times, at least 15.6us
// (R12) Upper result read clears end flag
// (R13) Read lower result before upper
// (R14) Busy high from start to finish
// (R15) Lower result bits 3:0 undefined
// (R16) Mode: off, single, repeat; off stops
// (R17) End stores result, flag, interrupt together
// (R18) Repeat restarts; stop discards result; a stop written in the finish cycle still loads res_reg
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "adcsq_map.vh"
module adcsq_top #(
  parameter FC_HZ  = `ADCSQ_FC_HZ,
  parameter CLK_HZ = `ADCSQ_CLK_HZ
) (
  input  wire        CLK_I,
  input  wire        RST_I,
  input  wire [11:0] S_AXI_AWADDR_I,
  input  wire        S_AXI_AWVALID_I,
  output reg         S_AXI_AWREADY_O,
  input  wire [31:0] S_AXI_WDATA_I,
  input  wire [3:0]  S_AXI_WSTRB_I,
  input  wire        S_AXI_WVALID_I,
  output reg         S_AXI_WREADY_O,
  output reg  [1:0]  S_AXI_BRESP_O,
  output reg         S_AXI_BVALID_O,
  input  wire        S_AXI_BREADY_I,
  input  wire [11:0] S_AXI_ARADDR_I,
  input  wire        S_AXI_ARVALID_I,
  output reg         S_AXI_ARREADY_O,
  output reg  [31:0] S_AXI_RDATA_O,
  output reg  [1:0]  S_AXI_RRESP_O,
  output reg         S_AXI_RVALID_O,
  input  wire        S_AXI_RREADY_I,
  input  wire [9:0]  SAMPLE_I,
  output reg  [1:0]  CHANNEL_SEL_O,
  output reg         CHANNEL_VALID_O,
  output reg         ANALOG_INPUT_DISABLE_O,
  output reg         CONVERSION_DONE_IRQ_O
);
  // Conversion clock equals system clock here; the ratio covers faster cores
  localparam integer FC_DIV = (CLK_HZ + FC_HZ - 1) / FC_HZ;

  function [11:0] conv_periods;
    input [2:0] code;
    begin
      case (code) // (R10)
        3'h0:    conv_periods = 12'd39;
        3'h2:    conv_periods = 12'd78;
        3'h3:    conv_periods = 12'd156;
        3'h4:    conv_periods = 12'd312;
        3'h5:    conv_periods = 12'd624;
        3'h6:    conv_periods = 12'd1248;
        default: conv_periods = 12'd0;
      endcase
    end
  endfunction

  function [1:0] chan_of;
    input [3:0] code;
    begin
      chan_of = code[1:0];
    end
  endfunction

  function chan_ok;
    input [3:0] code;
    begin
      chan_ok = (code == 4'h1) || (code == 4'h2) || (code == 4'h3); // (R1)
    end
  endfunction

  reg [7:0]  ctrl1_reg;
  reg [7:0]  ctrl2_reg;
  reg        busy_reg;
  reg        eoc_reg;
  reg [11:0] cnt_reg;
  reg [7:0]  div_reg;
  reg [2:0]  hold_reg;
  reg [9:0]  res_reg;
  reg        irq_st_reg;
  reg        irq_msk_reg;
  reg        aw_got_reg;
  reg        w_got_reg;
  reg [11:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0]  wstrb_reg;
  reg [7:0]  rd_flags_lo;

  wire [1:0] mode     = ctrl1_reg[`ADCSQ_C1_MODE_HI:`ADCSQ_C1_MODE_LO];
  wire [3:0] chan     = ctrl1_reg[3:0];
  wire       fc_tick  = (div_reg == 8'h00);
  wire [11:0] periods = conv_periods(ctrl2_reg[3:1]);
  wire       aw_have  = aw_got_reg | S_AXI_AWVALID_I;
  wire       w_have   = w_got_reg | S_AXI_WVALID_I;
  wire [11:0] waddr   = aw_got_reg ? awaddr_reg : S_AXI_AWADDR_I;
  wire [31:0] wdata   = w_got_reg ? wdata_reg : S_AXI_WDATA_I;
  wire [3:0]  wstrb   = w_got_reg ? wstrb_reg : S_AXI_WSTRB_I;
  wire       do_wr    = aw_have & w_have & ~S_AXI_BVALID_O;
  wire       wr_c1    = do_wr & wstrb[0] & (waddr == `ADCSQ_OFF_CTRL1);
  wire       wr_c2    = do_wr & wstrb[0] & (waddr == `ADCSQ_OFF_CTRL2);
  wire       do_rd    = S_AXI_ARVALID_I & ~S_AXI_RVALID_O;
  wire       rd_hi    = do_rd & (S_AXI_ARADDR_I == `ADCSQ_OFF_RESHI);
  wire       finish   = busy_reg & fc_tick & (cnt_reg == 12'd1);
  wire       start_req = ctrl1_reg[`ADCSQ_C1_START] & ~busy_reg &
                         (hold_reg == 3'h0) & (mode != `ADCSQ_MODE_OFF) &
                         (mode != 2'h2) & (periods != 12'd0);
  wire       restart  = finish & (mode == `ADCSQ_MODE_REPEAT); // (R18)
  wire [9:0] mem_q;

  // Result also kept per channel; register reads use res_reg and mem_q is never read
  adcsq_result_mem #(.DEPTH(4)) u_mem (
    .CLK_I     (CLK_I),
    .RST_I     (RST_I),
    .wr_en_i   (finish & mode != `ADCSQ_MODE_OFF),
    .wr_addr_i (chan_of(chan)),
    .wr_data_i (SAMPLE_I),
    .rd_addr_i (chan_of(chan)),
    .rd_data_o (mem_q)
  );

  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      div_reg <= 8'h00;
    end else if (fc_tick) begin
      div_reg <= FC_DIV[7:0] - 8'h01;
    end else begin
      div_reg <= div_reg - 8'h01;
    end
  end

  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl1_reg   <= `ADCSQ_C1_RESET; // (R6)
      ctrl2_reg   <= `ADCSQ_C2_RESET;
      busy_reg    <= 1'b0;
      eoc_reg     <= 1'b0;
      cnt_reg     <= 12'h000;
      hold_reg    <= 3'h0;
      irq_st_reg  <= 1'b0;
      irq_msk_reg <= 1'b0;
    end else begin
      if (hold_reg != 3'h0)
        hold_reg <= hold_reg - 3'h1;
      if (wr_c1) begin
        ctrl1_reg <= wdata[7:0];
        if (wdata[7:0] == 8'h00)
          hold_reg <= `ADCSQ_START_HOLD; // (R7)
      end else if (start_req) begin
        ctrl1_reg[`ADCSQ_C1_START] <= 1'b0; // (R4)
      end
      if (wr_c2)
        ctrl2_reg <= wdata[7:0] & `ADCSQ_C2_WMASK;
      if (wr_c1 && wdata[6:5] == `ADCSQ_MODE_OFF) begin
        busy_reg <= 1'b0; // (R16)
        cnt_reg  <= 12'h000; // (R18)
      end else if (start_req || restart) begin
        busy_reg <= 1'b1; // (R14)
        cnt_reg  <= periods;
      end else if (finish) begin
        busy_reg <= 1'b0; // (R14)
      end else if (busy_reg && fc_tick) begin
        cnt_reg <= cnt_reg - 12'd1;
      end
      // Set beats the read clear
      if (finish && !(wr_c1 && wdata[6:5] == `ADCSQ_MODE_OFF))
        eoc_reg <= 1'b1; // (R17)
      else if (rd_hi)
        eoc_reg <= 1'b0; // (R12)
      if (finish && !(wr_c1 && wdata[6:5] == `ADCSQ_MODE_OFF))
        irq_st_reg <= 1'b1; // (R17)
      else if (do_wr && wstrb[0] && waddr == `ADCSQ_OFF_IRQST && wdata[0])
        irq_st_reg <= 1'b0;
      if (do_wr && wstrb[0] && waddr == `ADCSQ_OFF_IRQMSK)
        irq_msk_reg <= wdata[0];
    end
  end

  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      res_reg <= 10'h000;
    end else if (finish && mode != `ADCSQ_MODE_OFF) begin
      res_reg <= SAMPLE_I; // (R17)
    end
  end

  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CHANNEL_SEL_O          <= 2'h0;
      CHANNEL_VALID_O        <= 1'b0;
      ANALOG_INPUT_DISABLE_O <= 1'b0;
      CONVERSION_DONE_IRQ_O  <= 1'b0;
    end else begin
      CHANNEL_SEL_O          <= chan_of(chan); // (R1)
      CHANNEL_VALID_O        <= chan_ok(chan); // (R1)
      ANALOG_INPUT_DISABLE_O <= ctrl1_reg[`ADCSQ_C1_AINDIS];
      CONVERSION_DONE_IRQ_O  <= irq_st_reg & irq_msk_reg;
    end
  end

  always @* begin
    rd_flags_lo = {res_reg[1:0], eoc_reg, busy_reg, 4'h0}; // (R15)
  end

  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      aw_got_reg      <= 1'b0;
      w_got_reg       <= 1'b0;
      awaddr_reg      <= 12'h000;
      wdata_reg       <= 32'h00000000;
      wstrb_reg       <= 4'h0;
      S_AXI_AWREADY_O <= 1'b1;
      S_AXI_WREADY_O  <= 1'b1;
      S_AXI_BVALID_O  <= 1'b0;
      S_AXI_BRESP_O   <= 2'h0;
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_RRESP_O   <= 2'h0;
      S_AXI_RDATA_O   <= 32'h00000000;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O && !do_wr) begin
        aw_got_reg      <= 1'b1;
        awaddr_reg      <= S_AXI_AWADDR_I;
        S_AXI_AWREADY_O <= 1'b0;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O && !do_wr) begin
        w_got_reg      <= 1'b1;
        wdata_reg      <= S_AXI_WDATA_I;
        wstrb_reg      <= S_AXI_WSTRB_I;
        S_AXI_WREADY_O <= 1'b0;
      end
      if (do_wr) begin
        aw_got_reg      <= 1'b0;
        w_got_reg       <= 1'b0;
        S_AXI_AWREADY_O <= 1'b0;
        S_AXI_WREADY_O  <= 1'b0;
        S_AXI_BVALID_O  <= 1'b1;
        S_AXI_BRESP_O   <= (waddr[11:5] == 7'h00 && waddr[4:0] <= 5'h14
                            && waddr[1:0] == 2'h0) ? 2'h0 : 2'h2;
      end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O  <= 1'b0;
        S_AXI_AWREADY_O <= 1'b1;
        S_AXI_WREADY_O  <= 1'b1;
      end
      if (do_rd) begin
        S_AXI_ARREADY_O <= 1'b0;
        S_AXI_RVALID_O  <= 1'b1;
        S_AXI_RRESP_O   <= 2'h0;
        case (S_AXI_ARADDR_I)
          `ADCSQ_OFF_CTRL1:  S_AXI_RDATA_O <= {24'h0, ctrl1_reg};
          `ADCSQ_OFF_CTRL2:  S_AXI_RDATA_O <= {24'h0, ctrl2_reg}; // (R9)
          `ADCSQ_OFF_RESHI:  S_AXI_RDATA_O <= {24'h0, res_reg[9:2]};
          `ADCSQ_OFF_RESLO:  S_AXI_RDATA_O <= {24'h0, rd_flags_lo};
          `ADCSQ_OFF_IRQST:  S_AXI_RDATA_O <= {31'h0, irq_st_reg};
          `ADCSQ_OFF_IRQMSK: S_AXI_RDATA_O <= {31'h0, irq_msk_reg};
          default: begin
            S_AXI_RDATA_O <= 32'h00000000;
            S_AXI_RRESP_O <= 2'h2;
          end
        endcase
      end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
        S_AXI_RVALID_O  <= 1'b0;
        S_AXI_ARREADY_O <= 1'b1;
      end
    end
  end
endmodule // adcsq_top
`default_nettype wire

// File: tb/adcsq_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module adcsq_monitor (
  input wire logic        CLK_I, RST_I,
  input wire logic        S_AXI_AWVALID_I, S_AXI_AWREADY_O,
  input wire logic        S_AXI_WVALID_I, S_AXI_WREADY_O,
  input wire logic        S_AXI_BVALID_O, S_AXI_BREADY_I,
  input wire logic        S_AXI_ARVALID_I, S_AXI_ARREADY_O,
  input wire logic        S_AXI_RVALID_O, S_AXI_RREADY_I, CHANNEL_VALID_O,
  input wire logic [11:0] S_AXI_ARADDR_I,
  input wire logic [1:0]  S_AXI_BRESP_O, S_AXI_RRESP_O, CHANNEL_SEL_O,
  input wire logic [31:0] S_AXI_RDATA_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  bresp_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
    |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("bvalid drop");
  rdata_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
    |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("rvalid drop");
  read_answer_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
    |=> S_AXI_RVALID_O) else $error("read not answered");
  write_answer_a: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O &&
    S_AXI_WVALID_I && S_AXI_WREADY_O |=> S_AXI_BVALID_O)
    else $error("write not answered");
  read_block_a: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
    else $error("read taken while busy");
  write_block_a: assert property (S_AXI_BVALID_O
    |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O) else $error("write overlap");
  bad_read_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O &&
    S_AXI_ARADDR_I > 12'h014 |=> S_AXI_RRESP_O == 2'h2 &&
    S_AXI_RDATA_O == 32'h0) else $error("unmapped read accepted");
  chan_valid_a: assert property (
    CHANNEL_VALID_O |-> CHANNEL_SEL_O != 2'h0) else $error("bad channel");
endmodule // adcsq_monitor
bind adcsq_top adcsq_monitor adcsq_monitor_inst (.*);
`default_nettype wire

// File: tb/adcsq_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "adcsq_map.vh"
module adcsq_top_tb;
  logic        clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic        awr, wrd, bv, arr, rv, chv, aid, irq;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat, v;
  logic [1:0]  br, rr, chs;
  logic [9:0]  smp = 10'h2b5;
  int          fails = 0, n_tests = 0, cyc = 0, t, n;
  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  adcsq_top adcsq_top_inst (.CLK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awa),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd),
    .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(rry), .SAMPLE_I(smp), .CHANNEL_SEL_O(chs),
    .CHANNEL_VALID_O(chv), .ANALOG_INPUT_DISABLE_O(aid),
    .CONVERSION_DONE_IRQ_O(irq));
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic hang(input int k);
    if (k >= 50) begin
      fails++;
      test_done;
    end
  endtask
  // Ready comes a cycle late so the response-hold checks see a stall
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] e = 2'h0);
    int k;
    logic pa, pw;
    pa = 1'h1;
    pw = 1'h1;
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    for (k = 0; k < 50 && (pa || pw); k++) begin
      @(posedge clk);
      if (awr) awv <= 1'h0;
      if (wrd) wv <= 1'h0;
      pa = pa && !awr;
      pw = pw && !wrd;
    end
    hang(k);
    @(posedge clk);
    bry <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (bv) break;
    end
    hang(k);
    bry <= 1'h0;
    chk(br, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [1:0] e = 2'h0);
    int k;
    ara <= a;
    arv <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (arr) break;
    end
    hang(k);
    arv <= 1'h0;
    @(posedge clk);
    rry <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (rv) break;
    end
    hang(k);
    rry <= 1'h0;
    v = rdat;
    chk(rr, e);
  endtask
  task automatic till(input int c);
    while (cyc < c) @(posedge clk);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rd(`ADCSQ_OFF_CTRL1);
    chk(v[7:0], `ADCSQ_C1_RESET);
    chk(chv, 1'h0);
    rd(`ADCSQ_OFF_CTRL2);
    chk(v[5:0], 6'h10);
    for (int c = 1; c < 5; c++) begin
      wr(`ADCSQ_OFF_CTRL1, c | (c == 4 ? 32'h10 : 32'h0));
      chk({aid, chv, chs}, {c == 4, c < 4, c[1:0]});
    end
    wr(`ADCSQ_OFF_IRQMSK, 32'h1);
    for (int i = 0; i < 2; i++) begin
      // Shorter codes are inhibited at this clock, so only 312 and 624 run
      n = 312 << i;
      smp <= 10'h2b5 ^ {10{i[0]}};
      wr(`ADCSQ_OFF_CTRL2, 32'h18 | i << 1);
      wr(`ADCSQ_OFF_CTRL1, 32'ha1);
      t = cyc;
      rd(`ADCSQ_OFF_CTRL1);
      chk(v[7:0], 8'h21);
      till(t + n - 8);
      rd(`ADCSQ_OFF_RESLO);
      chk(v[5:4], 2'h1);
      till(t + n + 6);
      rd(`ADCSQ_OFF_RESLO);
      chk(v[7:4], {smp[1:0], 2'h2});
      chk(irq, 1'h1);
      rd(`ADCSQ_OFF_RESHI);
      chk(v[7:0], smp[9:2]);
      rd(`ADCSQ_OFF_RESLO);
      chk(v[5], 1'h0);
      wr(`ADCSQ_OFF_IRQST, 32'h1);
      chk(irq, 1'h0);
    end
    smp <= 10'h3c7;
    wr(`ADCSQ_OFF_CTRL1, 32'he1);
    t = cyc;
    for (int j = 1; j < 3; j++) begin
      till(t + j * n + 6);
      rd(`ADCSQ_OFF_RESLO);
      chk(v[7:5], {smp[1:0], 1'h1});
      rd(`ADCSQ_OFF_RESHI);
    end
    wr(`ADCSQ_OFF_CTRL1, 32'h01);
    till(cyc + n + 8);
    rd(`ADCSQ_OFF_RESLO);
    chk(v[5:4], 2'h0);
    chk(irq, 1'h1);
    wr(`ADCSQ_OFF_IRQMSK, 32'h0);
    chk(irq, 1'h0);
    wr(`ADCSQ_OFF_IRQST, 32'h1);
    wr(`ADCSQ_OFF_IRQMSK, 32'h1);
    chk(irq, 1'h0);
    rd(12'h020, 2'h2);
    chk(v, 32'h0);
    wr(12'h020, 32'h0, 2'h2);
    test_done;
  end
endmodule // adcsq_top_tb
`default_nettype wire
